// ### design/pc_stack.sv
`timescale 1ns/1ps
// Overview of operation
// - return pops, increments, loads program counter
// - return on empty stack forces reset
// - interrupt pushes; interrupt_return pops it
// - thirty levels, software keeps calls paired
// - returns unwind strictly last in first out
// - indirect call pushes, jumps to register pair
// - target is low nibble plus second byte
// - push beyond capacity forces reset
// - false condition leaves stack, advances by one (interrupt_return, load-and-return pop regardless)
// - load-and-return writes constant over two cycles
module pc_stack #(
  parameter int unsigned DEPTH = pc_stack_pkg::STACK_DEPTH
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // decoded operation, one per valid pulse
  input  wire logic        op_valid_i,
  input  wire logic [3:0]  op_i,
  input  wire logic        cond_true_i,
  input  wire logic [11:0] target_i,
  input  wire logic [7:0]  first_operand_register_i,
  input  wire logic [7:0]  second_operand_register_i,
  input  wire logic [3:0]  dest_reg_i,
  input  wire logic [7:0]  constant_i,
  // results
  output logic [11:0]      program_counter_o,
  output logic             busy_o,
  output logic             reg_we_o,
  output logic [3:0]       reg_addr_o,
  output logic [7:0]       reg_data_o,
  output logic             internal_reset_o,
  output logic [4:0]       depth_o
);

  logic [11:0] stack_mem [DEPTH];
  logic [11:0] program_counter_r;
  logic [4:0]  sp_r;
  logic        busy_r;
  logic        reg_we_r;
  logic [3:0]  reg_addr_r;
  logic [7:0]  reg_data_r;
  logic        int_rst_r;
  pc_stack_pkg::op_t op;
  logic        go;
  logic        is_push;
  logic        is_pop;
  logic        overflow;
  logic        underflow;
  logic [11:0] top_plus;

  // 12-bit increment without width growth
  function automatic logic [11:0] inc12(input logic [11:0] v);
    inc12 = v + 12'h001;
  endfunction

  // decode of the requested operation
  always_comb begin
    op      = pc_stack_pkg::op_t'(op_i);
    go      = op_valid_i && !busy_r && !int_rst_r;
    is_push = go && cond_true_i &&
              (op == pc_stack_pkg::OP_CALL || op == pc_stack_pkg::OP_CALL_IND
               || op == pc_stack_pkg::OP_INTR);
    is_pop  = go && (cond_true_i || op == pc_stack_pkg::OP_LOAD_RET
               || op == pc_stack_pkg::OP_INT_RET) &&
              (op == pc_stack_pkg::OP_RETURN || op == pc_stack_pkg::OP_INT_RET
               || op == pc_stack_pkg::OP_LOAD_RET);
    overflow  = is_push && (sp_r == 5'(DEPTH));
    underflow = is_pop && (sp_r == pc_stack_pkg::SP_RESET);
    // an empty stack reads no entry: the underflow path restarts instead
    top_plus  = (sp_r == pc_stack_pkg::SP_RESET) ? 12'h000
                : inc12(stack_mem[sp_r - 5'h01]);
  end

  // internal reset pulse on stack fault
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      int_rst_r <= 1'b0;
    end else begin
      int_rst_r <= overflow || underflow;
    end
  end

  // stack pointer; fault or reset empties it
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sp_r <= pc_stack_pkg::SP_RESET;
    end else if (int_rst_r || overflow || underflow) begin
      sp_r <= pc_stack_pkg::SP_RESET;
    end else if (is_push) begin
      sp_r <= sp_r + 5'h01;
    end else if (is_pop) begin
      sp_r <= sp_r - 5'h01;
    end
  end

  // stack storage, thirty entries
  always_ff @(posedge clk_i) begin
    if (is_push && !overflow) begin
      stack_mem[sp_r] <= program_counter_r;
    end
  end

  // program counter update
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      program_counter_r <= pc_stack_pkg::PC_RESET;
    end else if (int_rst_r || overflow || underflow) begin
      program_counter_r <= pc_stack_pkg::PC_RESET;
    end else if (is_pop) begin
      program_counter_r <= top_plus;
    end else if (is_push) begin
      if (op == pc_stack_pkg::OP_CALL_IND) begin
        // low nibble of first, all of second
        program_counter_r <= {first_operand_register_i[3:0],
                              second_operand_register_i};
      end else begin
        program_counter_r <= target_i;
      end
    end else if (go && op != pc_stack_pkg::OP_NONE) begin
      program_counter_r <= (op == pc_stack_pkg::OP_JUMP && cond_true_i)
                           ? target_i : inc12(program_counter_r);
    end
  end

  // load-and-return register write and second cycle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_r     <= 1'b0;
      reg_we_r   <= 1'b0;
      reg_addr_r <= 4'h0;
      reg_data_r <= 8'h00;
    end else begin
      busy_r   <= go && op == pc_stack_pkg::OP_LOAD_RET && !underflow;
      reg_we_r <= go && op == pc_stack_pkg::OP_LOAD_RET && !underflow;
      if (go && op == pc_stack_pkg::OP_LOAD_RET) begin
        reg_addr_r <= dest_reg_i;
        reg_data_r <= constant_i;
      end
    end
  end

  // outputs straight from flip-flops
  always_comb begin
    program_counter_o = program_counter_r;
    busy_o            = busy_r;
    reg_we_o          = reg_we_r;
    reg_addr_o        = reg_addr_r;
    reg_data_o        = reg_data_r;
    internal_reset_o  = int_rst_r;
    depth_o           = sp_r;
  end

  // checks
  a_underflow_reset: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    underflow |=> int_rst_r && program_counter_r == 12'h000)
    else $error("underflow did not reset");
  a_overflow_reset: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    overflow |=> int_rst_r && sp_r == 5'h00)
    else $error("overflow did not reset");
  a_return_target: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    is_pop && !underflow |=> program_counter_r == $past(top_plus))
    else $error("return target wrong");
  a_push_depth: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    is_push && !overflow |=> sp_r == $past(sp_r) + 5'h01)
    else $error("push did not grow stack");
  a_lifo_pop: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    is_pop && !underflow |=> sp_r == $past(sp_r) - 5'h01)
    else $error("pop did not shrink stack");
  a_depth_limit: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    sp_r <= 5'(DEPTH))
    else $error("stack depth beyond capacity");
  a_indirect_target: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    is_push && !overflow && op == pc_stack_pkg::OP_CALL_IND |=>
    program_counter_r == {$past(first_operand_register_i[3:0]),
                          $past(second_operand_register_i)})
    else $error("indirect target wrong");
  a_cond_false: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    go && !cond_true_i && (op == pc_stack_pkg::OP_CALL ||
    op == pc_stack_pkg::OP_RETURN) |=> sp_r == $past(sp_r) &&
    program_counter_r == $past(program_counter_r) + 12'h001)
    else $error("false condition touched stack");
  a_loadret_busy: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    go && op == pc_stack_pkg::OP_LOAD_RET && !underflow |=>
    busy_r && reg_we_r ##1 !busy_r)
    else $error("load-and-return timing wrong");
  // refused operations while busy leave the stack and counter alone
  a_busy_holds: assert property (@(posedge clk_i)
    disable iff (!arst_n_i)
    busy_r |=> program_counter_r == $past(program_counter_r) &&
    sp_r == $past(sp_r))
    else $error("operation accepted while busy");
  a_loadret_data: assert property (@(posedge clk_i)
    disable iff (!arst_n_i)
    go && op == pc_stack_pkg::OP_LOAD_RET && !underflow |=>
    reg_addr_r == $past(dest_reg_i) && reg_data_r == $past(constant_i))
    else $error("load-and-return write wrong");
  // internal reset is a single pulse with the stack already emptied
  a_fault_single: assert property (@(posedge clk_i)
    disable iff (!arst_n_i)
    int_rst_r |=> !int_rst_r)
    else $error("internal reset longer than one cycle");
  a_fault_state: assert property (@(posedge clk_i)
    disable iff (!arst_n_i)
    int_rst_r |-> program_counter_r == 12'h000 && sp_r == 5'h00)
    else $error("internal reset left state behind");
  c_nested_call: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    is_push ##1 is_push);
  c_full_stack: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    sp_r == 5'(DEPTH));
  c_underflow: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    underflow);
  c_loadret: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    reg_we_r);
  c_indirect: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    is_push && op == pc_stack_pkg::OP_CALL_IND);

endmodule

// ### include/pc_stack_pkg.sv
package pc_stack_pkg;
  // program counter width and stack capacity
  localparam int unsigned PC_W        = 12;
  localparam int unsigned STACK_DEPTH = 30;
  localparam int unsigned SP_W        = 5;
  // value after reset
  localparam logic [11:0] PC_RESET    = 12'h000;
  localparam logic [4:0]  SP_RESET    = 5'h00;
  // cycles taken by the combined load-and-return operation
  localparam int unsigned LOADRET_CYCLES = 2;
  // operation codes presented by the instruction decoder
  typedef enum logic [3:0] {
    OP_NONE     = 4'h0,
    OP_CALL     = 4'h1,
    OP_CALL_IND = 4'h2,
    OP_RETURN   = 4'h3,
    OP_INT_RET  = 4'h4,
    OP_LOAD_RET = 4'h5,
    OP_INTR     = 4'h6,
    OP_JUMP     = 4'h7
  } op_t;
endpackage

// ### tb/subroutine_call_return_stack_test.sv
`timescale 1ns/1ps
module subroutine_call_return_stack_test;
  logic        clk_i, arst_n_i, op_valid_i, cond_true_i;
  logic [3:0]  op_i, dest_reg_i, reg_addr_o;
  logic [11:0] target_i, program_counter_o, pc_e;
  logic [7:0]  first_operand_register_i, second_operand_register_i;
  logic [7:0]  constant_i, reg_data_o;
  logic        busy_o, reg_we_o, internal_reset_o;
  logic [4:0]  depth_o;
  logic [11:0] stk[$];
  int          n_errors, compares, cycles;
  // device under test
  pc_stack u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .op_valid_i(op_valid_i), .op_i(op_i), .cond_true_i(cond_true_i),
    .target_i(target_i), .first_operand_register_i(first_operand_register_i),
    .second_operand_register_i(second_operand_register_i),
    .dest_reg_i(dest_reg_i), .constant_i(constant_i),
    .program_counter_o(program_counter_o), .busy_o(busy_o),
    .reg_we_o(reg_we_o), .reg_addr_o(reg_addr_o), .reg_data_o(reg_data_o),
    .internal_reset_o(internal_reset_o), .depth_o(depth_o));
  // clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one operation presented for one cycle, taken on the rising edge half a cycle later
  task automatic op(input logic [3:0] c, input logic cd, input logic [11:0] t);
    @(negedge clk_i);
    op_valid_i = 1'b1;
    op_i = c;
    cond_true_i = cd;
    target_i = t;
    @(negedge clk_i);
    op_valid_i = 1'b0;
  endtask
  task automatic chk_state();
    chk({4'h0, program_counter_o}, {4'h0, pc_e});
    chk({11'h0, depth_o}, 16'(stk.size()));
  endtask
  task automatic push(input logic [3:0] c, input logic [11:0] t);
    stk.push_back(pc_e);
    op(c, 1'b1, t);
    pc_e = t;
    chk_state();
  endtask
  task automatic pop(input logic [3:0] c);
    pc_e = stk.pop_back() + 12'h001;
    op(c, 1'b1, 12'h000);
    chk_state();
  endtask
  task automatic fault(input logic [3:0] c);
    op(c, 1'b1, 12'h7ff);
    chk({15'h0, internal_reset_o}, 16'h0001);
    stk.delete();
    pc_e = 12'h000;
    chk_state();
    @(negedge clk_i);
    chk({15'h0, internal_reset_o}, 16'h0000);
  endtask
  task automatic t_indirect();
    first_operand_register_i = 8'hfa;
    second_operand_register_i = 8'h59;
    push(4'h2, 12'ha59);
    pop(4'h3);
  endtask
  task automatic t_nest();
    for (int i = 0; i < 30; i++) push(4'h1, 12'h100 + 12'(i));
    for (int i = 0; i < 30; i++) pop(4'h3);
  endtask
  task automatic t_cond();
    op(4'h1, 1'b0, 12'h555);
    pc_e++;
    chk_state();
    push(4'h6, 12'h3ff);
    op(4'h3, 1'b0, 12'h000);
    pc_e++;
    chk_state();
    pop(4'h4);
    op(4'h7, 1'b1, 12'h123);
    pc_e = 12'h123;
    chk_state();
    op(4'h7, 1'b0, 12'h0f0);
    pc_e++;
    chk_state();
    op(4'h0, 1'b1, 12'h777);
    chk_state();
  endtask
  task automatic t_loadret();
    push(4'h1, 12'h0a0);
    dest_reg_i = 4'h9;
    constant_i = 8'h5a;
    pop(4'h5);
    chk({busy_o, reg_we_o, reg_addr_o, reg_data_o}, 16'h395a);
    @(negedge clk_i);
    chk({14'h0, busy_o, reg_we_o}, 16'h0000);
  endtask
  task automatic t_faults();
    fault(4'h3);
    fault(4'h4);
    for (int i = 0; i < 30; i++) push(4'h1, 12'h200 + 12'(i));
    fault(4'h1);
    for (int i = 0; i < 30; i++) push(4'h6, 12'h300 + 12'(i));
    fault(4'h6);
  endtask
  task automatic t_reset();
    push(4'h1, 12'h444);
    arst_n_i = 1'b0;
    #10 stk.delete();
    pc_e = 12'h000;
    chk_state();
    @(negedge clk_i);
    arst_n_i = 1'b1;
    push(4'h1, 12'h010);
  endtask
  task automatic conclude();
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    {arst_n_i, op_valid_i, cond_true_i, op_i, target_i} = '0;
    {first_operand_register_i, second_operand_register_i} = '0;
    {dest_reg_i, constant_i} = '0;
    pc_e = 12'h000;
    repeat (10) @(negedge clk_i);
    arst_n_i = 1'b1;
    chk_state();
    t_indirect();
    t_nest();
    t_cond();
    t_loadret();
    t_faults();
    t_reset();
    conclude();
  end
endmodule
